// ==== verilog/ascii_to_hex_converter.sv ====
// single-cycle ascii to hex conversion with parity and range checks
`timescale 1ns/1ps
`include "hex_conv_regs.svh"

// Summary of operation
// [RQ1] start byte then leftward; after high byte take next word's low byte
// [RQ2] several characters converted in order toward higher source words
// [RQ3] digits written from start digit upward, wrapping digit 3 to 0
// [RQ4] untargeted destination nibbles keep their previous values
// [RQ5] codes 30-39 give 0-9, codes 41-46 give A-F, parity ignored
// [RQ6] any converted character outside hex codes sets the error flag
// [RQ7] parity failure on any converted character sets the error flag
// [RQ8] out-of-range designator field sets error; no error clears flag
// [RQ9] top bit of each source byte is the parity bit
// [RQ10] parity mode comes from the designator's top nibble
// [RQ11] mode 0: any set top bit is an error
// [RQ12] mode 1: odd count of ones in a byte is an error
// [RQ13] mode 2: even count of ones in a byte is an error
// [RQ14] designator 0121: no parity, high byte, three chars, digit 1
// [RQ15] designator 1011: even parity, low byte, two chars, digit 1
// [RQ16] at most four characters per operation
// [RQ17] nibble 0 digit, nibble 1 count minus one, nibble 2 start byte
// [RQ18] on any error the destination is left wholly unchanged
module ascii_to_hex_converter
  import hex_conv_pkg::*;
#(
  parameter int MAX_CHARS = `MAX_CHARS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input designator_type conversionDesignator,
  input source_type source,
  input wire logic [15:0] destIn,
  output result_type result,
  output logic done
);

  designator_type des;
  assign des = conversionDesignator;

  // byte stream: index 2k low byte, 2k+1 high byte of word k
  logic [7:0] bytes [0:7];
  assign bytes[0] = source.word0[7:0];
  assign bytes[1] = source.word0[15:8];
  assign bytes[2] = source.word1[7:0];
  assign bytes[3] = source.word1[15:8];
  assign bytes[4] = source.word2[7:0];
  assign bytes[5] = source.word2[15:8];
  assign bytes[6] = source.word3[7:0];
  assign bytes[7] = source.word3[15:8];

  wire parityOk = des.parity == `PARITY_NONE || des.parity == `PARITY_EVEN
    || des.parity == `PARITY_ODD; // [RQ10]
  wire countOk = des.countM1 < 4'(MAX_CHARS); // [RQ16]
  wire desigBad = !parityOk || !countOk || des.startByte > 4'h1
    || des.startDigit > 4'h3; // [RQ8] [RQ17]

  logic [15:0] merged;
  logic charBad;
  logic [2:0] idx;
  logic [1:0] dig;
  logic [7:0] ch;
  logic [6:0] code;
  logic [3:0] val;
  logic valid;
  logic parBad;

  always_comb begin
    merged = destIn;
    charBad = 1'b0;
    idx = 3'h0;
    dig = 2'h0;
    ch = 8'h00;
    code = 7'h00;
    val = 4'h0;
    valid = 1'b0;
    parBad = 1'b0;
    for (int i = 0; i < MAX_CHARS; i++) begin
      if (4'(i) <= des.countM1 && !desigBad) begin
        idx = 3'(i) + {2'h0, des.startByte[0]}; // [RQ1] [RQ2]
        dig = 2'(i) + des.startDigit[1:0]; // [RQ3]
        ch = bytes[idx];
        code = ch[6:0]; // [RQ9]
        valid = 1'b1;
        if (code >= 7'h30 && code <= 7'h39) begin
          val = code[3:0]; // [RQ5]
        end else if (code >= 7'h41 && code <= 7'h46) begin
          val = code[3:0] + 4'h9; // [RQ5]
        end else begin
          valid = 1'b0;
          val = 4'h0;
        end
        unique case (des.parity)
          `PARITY_NONE: parBad = ch[7]; // [RQ11]
          `PARITY_EVEN: parBad = ^ch; // [RQ12]
          default: parBad = ~^ch; // [RQ13]
        endcase
        if (!valid) charBad = 1'b1; // [RQ6]
        if (parBad) charBad = 1'b1; // [RQ7]
        merged[4*dig +: 4] = val; // [RQ4]
      end
    end
  end

  wire anyErr = desigBad || charBad;
  wire [15:0] nextDest = anyErr ? destIn : merged; // [RQ18]

  result_type result_q;
  logic done_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      result_q <= '{dest: `DEST_RESET, conversionErrorFlag: 1'b0};
      done_q <= 1'b0;
    end else begin
      done_q <= start;
      if (start) result_q <= '{dest: nextDest, conversionErrorFlag: anyErr};
    end
  end

  assign result = result_q;
  assign done = done_q;

  property p_err_flag;
    @(posedge clk) disable iff (!resetn)
      start |=> result.conversionErrorFlag == $past(anyErr);
  endproperty
  a_err_flag: assert property (p_err_flag) // [RQ8]
    else $error("error flag wrong");

  property p_hold_on_err;
    @(posedge clk) disable iff (!resetn)
      start && anyErr |=> result.dest == $past(destIn);
  endproperty
  a_hold_on_err: assert property (p_hold_on_err) // [RQ18]
    else $error("destination changed on error");

  property p_desig_bad;
    @(posedge clk) disable iff (!resetn)
      start && des.startDigit > 4'h3 |=> result.conversionErrorFlag;
  endproperty
  a_desig_bad: assert property (p_desig_bad) // [RQ8]
    else $error("bad designator not flagged");

  property p_none_parity;
    @(posedge clk) disable iff (!resetn)
      start && des == 16'h0000 && source.word0[7] |=>
        result.conversionErrorFlag;
  endproperty
  a_none_parity: assert property (p_none_parity) // [RQ11]
    else $error("set parity bit not flagged");

  property p_even_parity;
    @(posedge clk) disable iff (!resetn)
      start && des == 16'h1000 && ^source.word0[7:0] |=>
        result.conversionErrorFlag;
  endproperty
  a_even_parity: assert property (p_even_parity) // [RQ12]
    else $error("even parity miss");

  property p_odd_parity;
    @(posedge clk) disable iff (!resetn)
      start && des == 16'h2000 && ~^source.word0[7:0] |=>
        result.conversionErrorFlag;
  endproperty
  a_odd_parity: assert property (p_odd_parity) // [RQ13]
    else $error("odd parity miss");

  property p_untouched;
    @(posedge clk) disable iff (!resetn)
      start && des == 16'h0121 |=>
        result.dest[3:0] == $past(destIn[3:0]);
  endproperty
  a_untouched: assert property (p_untouched) // [RQ4] [RQ14]
    else $error("untargeted digit 0 changed");

  property p_digit_map;
    @(posedge clk) disable iff (!resetn)
      start && des == 16'h0000 && source.word0[7:0] == 8'h41 |=>
        result.dest[3:0] == 4'ha && !result.conversionErrorFlag;
  endproperty
  a_digit_map: assert property (p_digit_map) // [RQ5]
    else $error("code 41 not mapped to a");

  property p_wrap;
    @(posedge clk) disable iff (!resetn)
      start && des == 16'h0013 && source.word0 == 16'h3231 |=>
        result.dest[3:0] == 4'h2 && result.dest[15:12] == 4'h1;
  endproperty
  a_wrap: assert property (p_wrap) // [RQ3] [RQ1]
    else $error("digit wrap wrong");

  // a bad last character must not leave the good first digit behind
  property p_no_partial;
    @(posedge clk) disable iff (!resetn)
      start && des == 16'h0010 && source.word0[15:8] == 8'h3a |=>
        result.dest == $past(destIn) && result.conversionErrorFlag;
  endproperty
  a_no_partial: assert property (p_no_partial) // [RQ18] [RQ6]
    else $error("partial result written on error");

  property p_full_count;
    @(posedge clk) disable iff (!resetn)
      start && des == 16'h0033 && source.word0 == 16'h4241
        && source.word1 == 16'h4643 |=>
        result.dest == 16'hafcb && !result.conversionErrorFlag;
  endproperty
  a_full_count: assert property (p_full_count) // [RQ16] [RQ3]
    else $error("four character conversion wrong");

  property p_done;
    @(posedge clk) disable iff (!resetn) start |=> done;
  endproperty
  a_done: assert property (p_done)
    else $error("done missing");

  c_ok: cover property (@(posedge clk) disable iff (!resetn)
    start ##1 !result.conversionErrorFlag);
  c_err: cover property (@(posedge clk) disable iff (!resetn)
    start ##1 result.conversionErrorFlag);
  c_ex1: cover property (@(posedge clk) disable iff (!resetn)
    start && des == 16'h0121); // [RQ14]
  c_ex2: cover property (@(posedge clk) disable iff (!resetn)
    start && des == 16'h1011); // [RQ15]
  c_full: cover property (@(posedge clk) disable iff (!resetn)
    start && des.countM1 == 4'h3); // [RQ16]

endmodule : ascii_to_hex_converter

// ==== include/hex_conv_regs.svh ====
// layout, parity mode and limit constants for the ascii to hex converter
`ifndef HEX_CONV_REGS_SVH
`define HEX_CONV_REGS_SVH
`define DESIG_DIGIT_LSB 0
`define DESIG_COUNT_LSB 4
`define DESIG_BYTE_LSB 8
`define DESIG_PARITY_LSB 12
`define PARITY_NONE 4'h0
`define PARITY_EVEN 4'h1
`define PARITY_ODD 4'h2
`define MAX_CHARS 4
`define DEST_RESET 16'h0000
`endif

// ==== include/hex_conv_pkg.sv ====
// types for the ascii to hex converter
package hex_conv_pkg;
  typedef struct packed {
    logic [3:0] parity;
    logic [3:0] startByte;
    logic [3:0] countM1;
    logic [3:0] startDigit;
  } designator_type;
  typedef struct packed {
    logic [15:0] word3;
    logic [15:0] word2;
    logic [15:0] word1;
    logic [15:0] word0;
  } source_type;
  typedef struct packed {
    logic [15:0] dest;
    logic conversionErrorFlag;
  } result_type;
endpackage : hex_conv_pkg

// ==== test/core_model.sv ====
// core-side model that presents operands for one conversion request
`timescale 1ns/1ps
module core_model
  import hex_conv_pkg::*;
(
  input wire logic issue,
  input designator_type opDesig,
  input source_type opSrc,
  input wire logic [15:0] opDest,
  output logic start,
  output designator_type desig,
  output source_type src,
  output logic [15:0] destOut
);
  assign start = issue;
  assign desig = opDesig;
  // idle source and destination operands scrambled so stale values never pass as fresh; designator passed unchanged
  assign src = issue ? opSrc : ~opSrc;
  assign destOut = issue ? opDest : ~opDest;
endmodule : core_model

// ==== test/tb.sv ====
// self-checking bench for the ascii to hex converter
`timescale 1ns/1ps
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin \
  nMismatch++; $display("unexpected %0t: %h not %h", $time, a, b); end end
module tb;
  import hex_conv_pkg::*;
  typedef struct packed {
    logic [15:0] d;
    logic [63:0] s;
    logic [15:0] di;
    logic [15:0] dx;
    logic fx;
  } row_type;
  // designator, source words, old dest, expected dest, expected flag
  row_type rows [18] = '{
    '{16'h0121, 64'h35313300, 16'hffff, 16'h513f, 1'b0},
    '{16'h1011, 64'h36b1, 16'h0000, 16'h0610, 1'b0},
    '{16'h2003, 64'h00b6, 16'h1234, 16'h6234, 1'b0},
    '{16'h0033, 64'h46434241, 16'h0000, 16'hafcb, 1'b0},
    '{16'h0030, 64'h46413930, 16'h0000, 16'hfa90, 1'b0},
    '{16'h0000, 64'hff31, 16'h5555, 16'h5551, 1'b0},
    '{16'h0000, 64'h003a, 16'habcd, 16'habcd, 1'b1},
    '{16'h0000, 64'h00b1, 16'habcd, 16'habcd, 1'b1},
    '{16'h1000, 64'h0031, 16'habcd, 16'habcd, 1'b1},
    '{16'h2000, 64'h0036, 16'habcd, 16'habcd, 1'b1},
    '{16'h3000, 64'h0031, 16'habcd, 16'habcd, 1'b1},
    '{16'h0200, 64'h0031, 16'habcd, 16'habcd, 1'b1},
    '{16'h0004, 64'h0031, 16'habcd, 16'habcd, 1'b1},
    '{16'h0040, 64'h0031, 16'habcd, 16'habcd, 1'b1},
    '{16'h0000, 64'h0041, 16'h1230, 16'h123a, 1'b0},
    '{16'h0013, 64'h3231, 16'h0000, 16'h1002, 1'b0},
    '{16'h0010, 64'h3a31, 16'habcd, 16'habcd, 1'b1},
    '{16'h0131, 64'h44434241_00, 16'h0000, 16'hcbad, 1'b0}
  };
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic issue = 1'b0;
  designator_type opDesig = '0;
  source_type opSrc = '0;
  logic [15:0] opDest = 16'h0000;
  logic start;
  designator_type desig;
  source_type src;
  logic [15:0] destOut;
  result_type result;
  logic done;
  int nMismatch = 0;
  int samplesChecked = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  core_model core_model_inst (.issue(issue), .opDesig(opDesig),
    .opSrc(opSrc), .opDest(opDest), .start(start), .desig(desig),
    .src(src), .destOut(destOut));
  ascii_to_hex_converter ascii_to_hex_converter_inst (.clk(clk),
    .resetn(resetn), .start(start), .conversionDesignator(desig),
    .source(src), .destIn(destOut), .result(result), .done(done));
  task automatic wrap_up;
    if (nMismatch == 0 && samplesChecked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic issue_row(input int i);
    issue = 1'b1;
    opDesig = rows[i].d;
    opSrc = rows[i].s;
    opDest = rows[i].di;
  endtask : issue_row
  always @(posedge clk) begin
    cycles++;
    if (cycles == 200) begin
      nMismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    `CHK(result, 17'h00000)
    `CHK(done, 1'b0)
    resetn = 1'b1;
    // back to back: each row is taken on the edge after the previous one
    for (int i = 0; i < 18; i++) begin
      issue_row(i);
      @(negedge clk);
      `CHK(done, 1'b1)
      `CHK(result, {rows[i].dx, rows[i].fx})
    end
    issue = 1'b0;
    @(negedge clk);
    `CHK(done, 1'b0)
    `CHK(result, {rows[17].dx, rows[17].fx})
    // reset arriving with a request must win
    issue_row(0);
    resetn = 1'b0;
    @(negedge clk);
    `CHK(result, 17'h00000)
    `CHK(done, 1'b0)
    wrap_up();
  end
endmodule : tb
